// [bench/fsw_bench.sv]
// self-checking bench: apb host end driving the flash end across the serial link
`timescale 1ns/1ns
module fsw_bench;
    import fsw_pkg::*;
    // long busy times so a status read fits inside a write cycle
    localparam int WR = 400;
    localparam int PR = 300;
    localparam int SEC = 300;
    localparam int BU = 300;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic area_protected = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, hw_protected, busy, op_start;
    logic [7:0] status;
    logic [23:0] frame_addr;
    fsw_op_t op_kind, last_kind;
    int error_cnt = 0;
    int n_compared = 0;
    int n_ops = 0;
    fsw_spi_if spi();
    always #25 pclk = ~pclk;
    fsw_spi_host #(.HALF(8)) fsw_spi_host_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .spi(spi.host));
    fsw_flash_dev #(.WRITE_CYCLES(WR), .PROGRAM_CYCLES(PR), .SECTOR_CYCLES(SEC),
        .BULK_CYCLES(BU)) fsw_flash_dev_inst(.pclk(pclk), .presetn(presetn), .spi(spi.dev),
        .area_protected(area_protected), .status(status), .hw_protected(hw_protected),
        .busy(busy), .frame_addr(frame_addr), .op_start(op_start), .op_kind(op_kind));
    fsw_link_chk #(.WR(WR), .PR(PR), .SEC(SEC), .BU(BU)) fsw_link_chk_inst(.pclk(pclk),
        .presetn(presetn), .cs_n(spi.cs_n), .wp_n(spi.wp_n), .area_protected(area_protected),
        .status(status), .hw_protected(hw_protected), .busy(busy), .op_start(op_start),
        .op_kind(op_kind));
    always @(posedge pclk) begin
        if (op_start === 1'b1) begin
            n_ops++;
            last_kind = op_kind;
        end
    end
    task close_out;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    // one apb transfer; holds the request until pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle limit here: only the watchdog may end a wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task frame(input logic [7:0] op, input logic [2:0] n, input logic [31:0] args,
        input logic [1:0] rp, output logic [7:0] last);
        logic [31:0] q;
        logic e;
        apb(1'b1, REG_ARGS, args, q, e);
        apb(1'b1, REG_CMD, {14'h0000, rp, 5'h00, n, op}, q, e);
        q = 32'h0000_0001;
        while (q[0] !== 1'b0) begin
            apb(1'b0, REG_STAT, 32'h0000_0000, q, e);
        end
        last = q[15:8];
    endtask
    task rd_chk(input logic [7:0] exp, input logic [1:0] rp);
        logic [7:0] v;
        frame(OP_READ_STATUS, 3'd0, 32'h0000_0000, rp, v);
        chk_byte(v, exp);
    endtask
    task cmd(input logic [7:0] op, input logic [2:0] n, input logic [31:0] args);
        logic [7:0] v;
        frame(op, n, args, 2'b00, v);
    endtask
    task pins_hw(input logic lvl, input logic exp);
        logic [31:0] q;
        logic e;
        int k;
        apb(1'b1, REG_PINS, {31'h0000_0000, lvl}, q, e);
        k = 0;
        while (hw_protected !== exp && k < 20) begin
            @(posedge pclk);
            k++;
        end
        chk_bit(hw_protected, exp);
    endtask
    task t_regs;
        logic [31:0] q;
        logic e;
        rd_chk(8'h00, 2'b01);
        apb(1'b0, REG_PINS, 32'h0000_0000, q, e);
        chk_bit(q[0], WP_RESET);
        apb(1'b0, 12'h010, 32'h0000_0000, q, e);
        chk_bit(e, 1'b1);
        chk_byte(q[7:0], 8'h00);
    endtask
    task t_status_write;
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_WRITE_DISABLE, 3'd0, 32'h0000_0000);
        cmd(OP_WRITE_STATUS, 3'd1, 32'h9c00_0000);
        rd_chk(8'h00, 2'b01);
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        rd_chk(8'h02, 2'b01);
        cmd(OP_WRITE_STATUS, 3'd1, 32'hff00_0000);
        chk_bit(busy, 1'b1);
        rd_chk(8'h9f, 2'b01);
        rd_chk(8'h9c, 2'b10);
        chk_byte({6'h00, last_kind}, {6'h00, OPK_STATUS});
    endtask
    task t_locked;
        pins_hw(1'b0, 1'b1);
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_WRITE_STATUS, 3'd1, 32'h0000_0000);
        rd_chk(8'h9e, 2'b01);
        pins_hw(1'b1, 1'b0);
        cmd(OP_WRITE_STATUS, 3'd1, 32'h0000_0000);
        rd_chk(8'h00, 2'b10);
        apb_pins_low_then_set();
    endtask
    task apb_pins_low_then_set;
        pins_hw(1'b0, 1'b0);
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_WRITE_STATUS, 3'd1, 32'h8000_0000);
        rd_chk(8'h80, 2'b10);
        chk_bit(hw_protected, 1'b1);
        pins_hw(1'b1, 1'b0);
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_WRITE_STATUS, 3'd1, 32'h0000_0000);
        rd_chk(8'h00, 2'b10);
    endtask
    task t_erase;
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_WRITE_STATUS, 3'd1, 32'h0400_0000);
        rd_chk(8'h04, 2'b10);
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_BULK_ERASE, 3'd0, 32'h0000_0000);
        rd_chk(8'h06, 2'b01);
        cmd(OP_WRITE_STATUS, 3'd1, 32'h0000_0000);
        rd_chk(8'h00, 2'b10);
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_WRITE_STATUS, 3'd2, 32'h8c8c_0000);
        rd_chk(8'h02, 2'b01);
        area_protected <= 1'b1;
        cmd(OP_SECTOR_ERASE, 3'd3, 32'h0100_0000);
        rd_chk(8'h02, 2'b01);
        area_protected <= 1'b0;
        cmd(OP_SECTOR_ERASE, 3'd3, 32'h0100_0000);
        chk_byte(frame_addr[23:16], 8'h01);
        rd_chk(8'h00, 2'b10);
        chk_byte({6'h00, last_kind}, {6'h00, OPK_SECTOR});
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_PAGE_PROGRAM, 3'd4, 32'h0100_005a);
        rd_chk(8'h00, 2'b10);
        chk_byte({6'h00, last_kind}, {6'h00, OPK_PROGRAM});
        cmd(OP_WRITE_ENABLE, 3'd0, 32'h0000_0000);
        cmd(OP_BULK_ERASE, 3'd0, 32'h0000_0000);
        rd_chk(8'h00, 2'b10);
        chk_byte({6'h00, last_kind}, {6'h00, OPK_BULK});
        chk_byte(8'(n_ops), 8'h09);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_status_write();
        t_locked();
        t_erase();
        close_out();
    end
    // about seven times the expected length of the whole sequence
    initial begin
        repeat (90000) @(posedge pclk);
        error_cnt++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end
endmodule

// [bench/fsw_link_chk.sv]
// assertions on the serial link and the flash end's status outputs
`timescale 1ns/1ns
module fsw_link_chk #(
    parameter int WR = 400,
    parameter int PR = 300,
    parameter int SEC = 300,
    parameter int BU = 300
) (
    input logic pclk,
    input logic presetn,
    input logic cs_n,
    input logic wp_n,
    input logic area_protected,
    input logic [7:0] status,
    input logic hw_protected,
    input logic busy,
    input logic op_start,
    input fsw_pkg::fsw_op_t op_kind
);
    import fsw_pkg::*;
    logic [15:0] busy_cnt;
    logic [15:0] exp_len;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // counts busy cycles so the length check needs no long repetition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= busy ? busy_cnt + 16'h0001 : 16'h0000;
        end
    end
    assign exp_len = op_kind == OPK_STATUS ? 16'(WR) : op_kind == OPK_PROGRAM ? 16'(PR) :
        op_kind == OPK_SECTOR ? 16'(SEC) : 16'(BU);
    AST_BUSY_FLAG: assert property (status[0] == busy && $rose(busy) == op_start)
        else $error("busy flag differs from busy output");
    AST_ZERO_BITS: assert property (status[6:5] == 2'b00)
        else $error("status bits 6 and 5 not zero");
    AST_LOCK_ON: assert property ((status[7] && !wp_n) [*6] |-> hw_protected)
        else $error("locked mode not entered");
    AST_LOCK_OFF: assert property (wp_n [*6] |-> !hw_protected)
        else $error("locked mode kept with pin high");
    AST_LOCK_HOLD: assert property (hw_protected && !wp_n |=> $stable(status[7:2]))
        else $error("protect bits changed in locked mode");
    AST_STATIC: assert property (!op_start |-> $stable(status[7:2]))
        else $error("protect bits changed without a status write");
    AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt == exp_len)
        else $error("busy cycle length wrong");
    AST_WEL_CLEAR: assert property ($fell(busy) |-> !status[1])
        else $error("latch not cleared at cycle end");
    AST_START_LATCH: assert property (op_start |-> status[1] && $rose(busy))
        else $error("cycle started without latch or busy");
    AST_START_AT_CS: assert property (op_start |-> cs_n && !$past(cs_n, 8))
        else $error("cycle started away from a select rise");
    AST_BULK_BP: assert property (op_start && op_kind == OPK_BULK |-> status[4:2] == 3'b000)
        else $error("bulk erase run with protect bits set");
    AST_AREA: assert property (op_start && op_kind inside {OPK_PROGRAM, OPK_SECTOR} |->
        !area_protected)
        else $error("protected area modified");
endmodule

// [rtl/fsw_flash_dev.sv]
// flash end: status byte, write-enable latch, protection and self-timed busy cycles
`timescale 1ns/1ns
module fsw_flash_dev #(
    parameter int WRITE_CYCLES = fsw_pkg::STATUS_WRITE_CYCLES,
    parameter int PROGRAM_CYCLES = fsw_pkg::PAGE_PROGRAM_CYCLES,
    parameter int SECTOR_CYCLES = fsw_pkg::SECTOR_ERASE_CYCLES,
    parameter int BULK_CYCLES = fsw_pkg::BULK_ERASE_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    fsw_spi_if.dev spi,
    input wire logic area_protected,
    output logic [7:0] status,
    output logic hw_protected,
    output logic busy,
    output logic [23:0] frame_addr,
    output logic op_start,
    output fsw_pkg::fsw_op_t op_kind
);
    import fsw_pkg::*;

    logic [2:0] sclk_q;
    logic [2:0] cs_q;
    logic [1:0] mosi_q;
    logic [1:0] wp_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_low;
    logic cs_rise;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [6:0] in_sr;
    logic [7:0] next_byte;
    logic [7:0] cmd;
    logic rd_phase;
    logic [2:0] out_cnt;
    logic [7:0] out_sr;
    logic miso;
    logic write_enable_latch;
    logic status_write_disable;
    logic [2:0] bp;
    logic hardware_protected_mode;
    logic [BUSY_CNT_W-1:0] busy_cnt;
    logic busy_done;
    logic at_boundary;
    logic frame_end;
    logic status_write_ok;
    logic program_ok;
    logic sector_ok;
    logic bulk_ok;
    logic [7:0] wr_data;

    // pins from the host cross into pclk; only stage 1 onward is looked at
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_q <= 3'b000;
            cs_q <= 3'b111;
            mosi_q <= 2'b00;
            wp_q <= 2'b11;
        end else begin
            sclk_q <= {sclk_q[1:0], spi.sclk};
            cs_q <= {cs_q[1:0], spi.cs_n};
            mosi_q <= {mosi_q[0], spi.mosi};
            wp_q <= {wp_q[0], spi.wp_n};
        end
    end

    assign sclk_rise = sclk_q[1] & ~sclk_q[2];
    assign sclk_fall = ~sclk_q[1] & sclk_q[2];
    assign cs_low = ~cs_q[1];
    assign cs_rise = cs_q[1] & ~cs_q[2];
    assign next_byte = {in_sr, mosi_q[1]};
    assign at_boundary = (bit_cnt == 3'd0);
    assign wr_data = frame_addr[23:16];

    // serial input sampled on rising clock edges while selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_sr <= 7'h00;
            bit_cnt <= 3'd0;
            byte_cnt <= 3'd0;
        end else if (!cs_low) begin
            bit_cnt <= 3'd0;
            byte_cnt <= 3'd0;
        end else if (sclk_rise) begin
            in_sr <= next_byte[6:0]; // RULE22
            bit_cnt <= bit_cnt + 3'd1;
            // count saturates: longer program frames are still whole bytes
            if (bit_cnt == 3'd7 && byte_cnt < BYTES_PROGRAM) begin
                byte_cnt <= byte_cnt + 3'd1;
            end
        end
    end

    // first byte is the opcode, the next three the address or the status data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= 8'h00;
            frame_addr <= 24'h00_0000;
        end else if (cs_low && sclk_rise && bit_cnt == 3'd7) begin
            unique case (byte_cnt)
                3'd0: cmd <= next_byte; // RULE22
                3'd1: frame_addr[23:16] <= next_byte;
                3'd2: frame_addr[15:8] <= next_byte;
                3'd3: frame_addr[7:0] <= next_byte;
                default: ;
            endcase
        end
    end

    // read-status answers even during busy; no busy check here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_phase <= 1'b0;
        end else if (!cs_low) begin
            rd_phase <= 1'b0; // RULE21
        end else if (sclk_rise && bit_cnt == 3'd7 && byte_cnt == 3'd0 &&
                     next_byte == OP_READ_STATUS) begin
            rd_phase <= 1'b1; // RULE1 RULE21
        end
    end

    // a fresh status snapshot is taken at every byte start, so updates show
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_cnt <= 3'd0;
            out_sr <= 8'h00;
            miso <= 1'b0;
        end else if (!rd_phase) begin
            out_cnt <= 3'd0;
            miso <= 1'b0;
        end else if (sclk_fall) begin
            out_cnt <= out_cnt + 3'd1;
            if (out_cnt == 3'd0) begin
                miso <= status[7]; // RULE3 RULE22
                out_sr <= {status[6:0], 1'b0};
            end else begin
                miso <= out_sr[7]; // RULE22
                out_sr <= {out_sr[6:0], 1'b0};
            end
        end
    end

    assign spi.miso = miso;

    // bits 6 and 5 are hard zero
    assign status = {status_write_disable, 2'b00, bp, write_enable_latch, busy}; // RULE4 RULE12

    // locked while the disable bit is set and the pin is low, in any order;
    // only the pin can release it since nothing can clear the bit meanwhile
    assign hardware_protected_mode = status_write_disable &
                                     ~wp_q[1]; // RULE9 RULE17 RULE18 RULE19

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw_protected <= 1'b0;
        end else begin
            hw_protected <= hardware_protected_mode;
        end
    end

    // decode happens only when select rises; a partial byte kills the frame
    assign frame_end = cs_rise & at_boundary & ~busy; // RULE13
    assign status_write_ok = frame_end && cmd == OP_WRITE_STATUS &&
                             byte_cnt == BYTES_STATUS_WRITE && write_enable_latch &&
                             !hardware_protected_mode; // RULE5 RULE9 RULE10 RULE15 RULE16 RULE17
    assign program_ok = frame_end && cmd == OP_PAGE_PROGRAM && byte_cnt == BYTES_PROGRAM &&
                        write_enable_latch && !area_protected; // RULE5 RULE7
    assign sector_ok = frame_end && cmd == OP_SECTOR_ERASE && byte_cnt == BYTES_SECTOR &&
                       write_enable_latch && !area_protected; // RULE5 RULE7
    assign bulk_ok = frame_end && cmd == OP_BULK_ERASE && byte_cnt == BYTES_SHORT &&
                     write_enable_latch && bp == 3'h0; // RULE5 RULE8

    // protect bits and the disable bit only move through a status write;
    // bits 1 and 0 of the data byte are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_write_disable <= DISABLE_RESET;
            bp <= BP_RESET;
        end else if (status_write_ok) begin
            status_write_disable <= wr_data[BIT_DISABLE]; // RULE6 RULE12
            bp <= wr_data[BIT_BP_HI -: 3]; // RULE6 RULE12
        end
    end

    // one self-timed cycle at a time; its length depends on the operation
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            busy_cnt <= '0;
            op_start <= 1'b0;
            op_kind <= OPK_STATUS;
        end else begin
            op_start <= 1'b0;
            if (status_write_ok) begin
                busy <= 1'b1; // RULE14
                busy_cnt <= BUSY_CNT_W'(WRITE_CYCLES);
                op_start <= 1'b1;
                op_kind <= OPK_STATUS;
            end else if (program_ok) begin
                busy <= 1'b1; // RULE4
                busy_cnt <= BUSY_CNT_W'(PROGRAM_CYCLES);
                op_start <= 1'b1;
                op_kind <= OPK_PROGRAM;
            end else if (sector_ok) begin
                busy <= 1'b1; // RULE4
                busy_cnt <= BUSY_CNT_W'(SECTOR_CYCLES);
                op_start <= 1'b1;
                op_kind <= OPK_SECTOR;
            end else if (bulk_ok) begin
                busy <= 1'b1; // RULE4
                busy_cnt <= BUSY_CNT_W'(BULK_CYCLES);
                op_start <= 1'b1;
                op_kind <= OPK_BULK;
            end else if (busy) begin
                busy_cnt <= busy_cnt - BUSY_CNT_W'(1);
                if (busy_done) begin
                    busy <= 1'b0; // RULE4 RULE14
                end
            end
        end
    end

    assign busy_done = busy && busy_cnt == BUSY_CNT_W'(1);

    // latch drops when any timed cycle ends; commands during busy are ignored, except read-status
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_enable_latch <= 1'b0;
        end else if (busy_done) begin
            write_enable_latch <= 1'b0; // RULE14
        end else if (frame_end && byte_cnt == BYTES_SHORT) begin
            if (cmd == OP_WRITE_ENABLE) begin
                write_enable_latch <= 1'b1; // RULE20 RULE10
            end else if (cmd == OP_WRITE_DISABLE) begin
                write_enable_latch <= 1'b0;
            end
        end
    end
endmodule

// [rtl/fsw_pkg.sv]
// constants, types and the rule summary for the flash status and write-protect link
// How it works
// RULE1: status readable anytime, even while busy
// RULE2: host polls busy flag before next command
// RULE3: status repeats while chip select stays low
// RULE4: busy flag high during any self-timed cycle
// RULE5: latch clear rejects write, program, erase
// RULE6: protect bits change only by status write
// RULE7: program, erase refused in protected area
// RULE8: bulk erase only with protect bits zero
// RULE9: disable bit plus low pin locks status
// RULE10: write-enable must precede each status write
// RULE11: host sends opcode then one data byte
// RULE12: bits 6,5,1,0 unwritten; 6,5 read zero
// RULE13: select must rise at byte end
// RULE14: valid write starts timed busy, clears latch
// RULE15: disable bit zero: pin level irrelevant
// RULE16: disable bit one, pin high: writable
// RULE17: disable bit one, pin low: writes refused
// RULE18: locked mode entered in either order
// RULE19: only pin going high leaves locked mode
// RULE20: write-enable command sets the latch
// RULE21: read-status turns output on until deselect
// RULE22: sample on rising, shift out msb-first falling
package fsw_pkg;
    localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;

    // status byte layout
    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_BP_HI = 4;
    localparam int BIT_DISABLE = 7;
    localparam logic [2:0] BP_RESET = 3'h0;
    localparam logic DISABLE_RESET = 1'b0;

    // frame byte counts that make each command valid
    localparam logic [2:0] BYTES_SHORT = 3'd1;
    localparam logic [2:0] BYTES_STATUS_WRITE = 3'd2;
    localparam logic [2:0] BYTES_SECTOR = 3'd4;
    localparam logic [2:0] BYTES_PROGRAM = 3'd5;

    localparam int CLK_PERIOD_NS = 50;
    localparam int STATUS_WRITE_TIME_NS = 5000;
    localparam int PAGE_PROGRAM_TIME_NS = 5000;
    localparam int SECTOR_ERASE_TIME_NS = 10000;
    localparam int BULK_ERASE_TIME_NS = 20000;
    localparam int STATUS_WRITE_CYCLES = (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_PROGRAM_CYCLES = (PAGE_PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SECTOR_ERASE_CYCLES = (SECTOR_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BULK_ERASE_CYCLES = (BULK_ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W = 16;

    // host side: half period of the generated serial clock in pclk cycles
    localparam int HOST_HALF_CYCLES = 8;
    localparam logic [11:0] REG_ARGS = 12'h000;
    localparam logic [11:0] REG_CMD = 12'h004;
    localparam logic [11:0] REG_STAT = 12'h008;
    localparam logic [11:0] REG_PINS = 12'h00c;
    localparam int CMD_ARGS_LO = 8;
    localparam int CMD_READ = 16;
    localparam int CMD_POLL = 17;
    localparam logic [31:0] ARGS_RESET = 32'h0000_0000;
    localparam logic WP_RESET = 1'b1;

    typedef enum logic [1:0] {
        OPK_STATUS,
        OPK_PROGRAM,
        OPK_SECTOR,
        OPK_BULK
    } fsw_op_t;
endpackage

// [rtl/fsw_spi_host.sv]
// host end: apb-controlled serial master that frames commands and polls status
`timescale 1ns/1ns
module fsw_spi_host #(
    parameter int HALF = fsw_pkg::HOST_HALF_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    fsw_spi_if.host spi
);
    import fsw_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE,
        H_LEAD,
        H_HIGH,
        H_LOW,
        H_TAIL,
        H_GAP
    } fsw_host_state_t;

    fsw_host_state_t state;
    logic [31:0] args;
    logic wp_level;
    logic [7:0] last_rx;
    logic [7:0] rx_sr;
    logic [39:0] tx_sr;
    logic [2:0] bit_cnt;
    logic [2:0] bytes_left;
    logic poll;
    logic [7:0] div;
    logic half_done;
    logic cs_n;
    logic sclk;
    logic [1:0] miso_q;
    logic mapped;
    logic wr_en;
    logic start;

    assign mapped = paddr == REG_ARGS || paddr == REG_CMD || paddr == REG_STAT ||
                    paddr == REG_PINS;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign wr_en = psel & penable & pwrite & mapped;
    // a command written while a frame runs is dropped
    assign start = wr_en && paddr == REG_CMD && state == H_IDLE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            unique case (paddr)
                REG_ARGS: prdata <= args;
                REG_STAT: prdata <= {16'h0000, last_rx, 7'h00, state != H_IDLE};
                REG_PINS: prdata <= {31'h0000_0000, wp_level};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            args <= ARGS_RESET;
            wp_level <= WP_RESET;
        end else if (wr_en) begin
            if (paddr == REG_ARGS) begin
                args <= pwdata;
            end
            if (paddr == REG_PINS) begin
                wp_level <= pwdata[0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_q <= 2'b00;
        end else begin
            miso_q <= {miso_q[0], spi.miso};
        end
    end

    assign half_done = div == 8'(HALF - 1);

    // each command is its own frame, so write-enable goes out ahead of
    // a status write as a separate frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= H_IDLE;
            cs_n <= 1'b1;
            sclk <= 1'b0;
            tx_sr <= 40'h00_0000_0000;
            rx_sr <= 8'h00;
            last_rx <= 8'h00;
            bit_cnt <= 3'd0;
            bytes_left <= 3'd0;
            poll <= 1'b0;
            div <= 8'h00;
        end else begin
            div <= half_done ? 8'h00 : div + 8'h01;
            unique case (state)
                H_IDLE: begin
                    div <= 8'h00;
                    if (start) begin
                        state <= H_LEAD; // RULE10
                        cs_n <= 1'b0; // RULE11
                        tx_sr <= {pwdata[7:0], args}; // RULE11
                        bytes_left <= 3'd1 + pwdata[CMD_ARGS_LO +: 3] +
                                      {2'b00, pwdata[CMD_READ] | pwdata[CMD_POLL]};
                        poll <= pwdata[CMD_POLL];
                        bit_cnt <= 3'd0;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (half_done) begin
                        state <= H_HIGH;
                        sclk <= 1'b1;
                        rx_sr <= {rx_sr[6:0], miso_q[1]};
                    end
                end
                H_HIGH: begin
                    if (half_done) begin
                        sclk <= 1'b0;
                        tx_sr <= {tx_sr[38:0], 1'b0};
                        bit_cnt <= bit_cnt + 3'd1;
                        state <= H_LOW;
                        if (bit_cnt == 3'd7) begin
                            last_rx <= rx_sr;
                            if (bytes_left > 3'd1) begin
                                bytes_left <= bytes_left - 3'd1;
                            end else if (!(poll && rx_sr[BIT_BUSY])) begin
                                state <= H_TAIL; // RULE2 RULE13
                            end
                        end
                    end
                end
                H_TAIL: begin
                    if (half_done) begin
                        cs_n <= 1'b1; // RULE13
                        state <= H_GAP;
                    end
                end
                H_GAP: begin
                    if (half_done) begin
                        state <= H_IDLE;
                    end
                end
            endcase
        end
    end

    assign spi.cs_n = cs_n;
    assign spi.sclk = sclk;
    assign spi.mosi = tx_sr[39];
    assign spi.wp_n = wp_level;
endmodule

// [rtl/fsw_spi_if.sv]
// serial link between the flash status logic and its host controller
`timescale 1ns/1ns
interface fsw_spi_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;
    logic wp_n;
    modport dev(
        input cs_n,
        input sclk,
        input mosi,
        input wp_n,
        output miso
    );
    modport host(
        output cs_n,
        output sclk,
        output mosi,
        output wp_n,
        input miso
    );
endinterface
